// ---- verilog/wake_cfg_consts.svh ----
// constants for the wake configuration, mask and temperature alert bank
`ifndef WAKE_CFG_CONSTS_SVH
`define WAKE_CFG_CONSTS_SVH

// ********
// register offsets
// ********
`define ADDR_WAKE_CONFIGURATION      8'h08
`define ADDR_INTERRUPT_MASK          8'h09
`define ADDR_TEMPERATURE_INTEGER     8'h0A
`define ADDR_TEMPERATURE_FRACTION    8'h0B
`define ADDR_TEMPERATURE_UPPER_LIMIT 8'h0C
`define ADDR_TEMPERATURE_LOWER_LIMIT 8'h0D
`define ADDR_UPPER_LIMIT_HYSTERESIS  8'h0E

// ********
// field positions
// ********
`define CFG_WAKE_CRIT_BIT   7
`define CFG_EVT_DIS_BIT     6
`define CFG_WAKE_SUPER_BIT  5
`define CFG_NET_PD_BIT      4
`define CFG_DELAY_MSB       2
`define MASK_LIN_BIT        6
`define MASK_SWITCH_BIT     4
`define MASK_STATUS_BIT     3
`define MASK_NET_BIT        2
`define MASK_THERMAL_BIT    1
`define MASK_SUPPLY_BIT     0
`define MASK_USED           8'h5F
`define FRACTION_LSB        5

// ********
// reset values
// ********
`define CFG_EVT_DIS_RESET    1'b1
`define CFG_WAKE_SUPER_RESET 1'b1
`define CFG_NET_PD_RESET     1'b0
`define CFG_DELAY_RESET      3'h7
`define MASK_RESET           8'h5F
`define UPPER_LIMIT_RESET    7'h55
`define LOWER_LIMIT_RESET    8'h00
`define BAND_WIDTH_RESET     5'h05
`define TEMPERATURE_RESET    11'h000

// ********
// timing
// ********
`define CLK_PERIOD_NS   50
`define TICK_TIME_NS    100000
`define TICK_CYCLES     (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define NET_DELAY_US_0  1200
`define NET_DELAY_US_1  2000
`define NET_DELAY_US_2  3000
`define NET_DELAY_US_3  4000
`define NET_DELAY_US_4  5000
`define NET_DELAY_US_5  6000
`define NET_DELAY_US_6  8000
`define NET_DELAY_US_7  10000
`define US_TO_TICKS(us) (((us) * 1000) / `TICK_TIME_NS)

`endif

// ---- verilog/wake_cfg_pkg.sv ----
// types shared by the wake configuration bank and its reset release timer
package wake_cfg_pkg;

    // ********
    // check and release states
    // ********
    typedef enum logic [0:0] {
        HI_WATCH_RISE = 1'b0,
        HI_WATCH_FALL = 1'b1
    } high_check_e;

    typedef enum logic [0:0] {
        LO_WATCH_FALL = 1'b0,
        LO_WATCH_RISE = 1'b1
    } low_check_e;

    typedef enum logic [1:0] {
        REL_HOLD  = 2'b00,
        REL_COUNT = 2'b01,
        REL_DONE  = 2'b11
    } release_e;

    // ********
    // module state
    // ********
    typedef struct packed {
        logic        wake_in_critical_region;
        logic        supply_event_disable;
        logic        wake_in_super_region;
        logic        net_detector_powerdown;
        logic [2:0]  net_wake_reset_delay;
        logic        strap_taken;
        logic [7:0]  mask;
        logic [10:0] temperature;
        logic [6:0]  upper_degree_limit;
        logic [7:0]  lower_degree_limit;
        logic [4:0]  upper_band_width;
        high_check_e high_check;
        low_check_e  low_check;
        logic [3:0]  prev_activity;
        logic [2:0]  prev_supply;
        logic        prev_sleep;
        logic [7:0]  flags;
        logic        power_applied_flag;
        logic        int_n;
        logic        wake_permit;
        logic [7:0]  rdata;
        logic [6:0]  delay_ticks;
    } bank_state_s;

    typedef struct packed {
        release_e    phase;
        logic [15:0] div;
        logic [6:0]  ticks;
        logic [6:0]  target;
        logic        release_n;
    } timer_state_s;

endpackage : wake_cfg_pkg

// ---- verilog/reset_release_timer.sv ----
// reset output generator: low while supply is bad, then low for a tick count
`include "wake_cfg_consts.svh"

module reset_release_timer #(
    parameter logic [15:0] TICK_CYCLES = 16'(`TICK_CYCLES)
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       supply_good_i,
    input  wire logic [6:0] delay_ticks_i,
    output logic            reset_out_n_o
);

    wake_cfg_pkg::timer_state_s st;
    wake_cfg_pkg::timer_state_s next_st;

    // ********
    // release sequence
    // ********
    always_comb begin
        next_st = st;
        if (!supply_good_i) begin
            next_st.phase     = wake_cfg_pkg::REL_HOLD;
            next_st.release_n = 1'b0;
            next_st.div       = 16'h0000;
            next_st.ticks     = 7'h00;
        end else begin
            case (st.phase)
                wake_cfg_pkg::REL_HOLD: begin
                    // delay latched once so a late cause change cannot stretch it
                    next_st.phase  = wake_cfg_pkg::REL_COUNT;
                    next_st.target = delay_ticks_i;
                end
                wake_cfg_pkg::REL_COUNT: begin
                    if (st.div == TICK_CYCLES - 16'h0001) begin
                        next_st.div   = 16'h0000;
                        next_st.ticks = st.ticks + 7'h01;
                        if (st.ticks + 7'h01 >= st.target) begin
                            next_st.phase     = wake_cfg_pkg::REL_DONE;
                            next_st.release_n = 1'b1;
                        end
                    end else begin
                        next_st.div = st.div + 16'h0001;
                    end
                end
                wake_cfg_pkg::REL_DONE: begin
                    next_st.release_n = 1'b1;
                end
                default: begin
                    next_st.phase = wake_cfg_pkg::REL_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{phase: wake_cfg_pkg::REL_HOLD, div: 16'h0000, ticks: 7'h00,
                    target: 7'h00, release_n: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign reset_out_n_o = st.release_n;

endmodule : reset_release_timer

// ---- verilog/wake_config_mask_temp_alert.sv ----
// wake configuration, interrupt mask, temperature readout and alert bank
// Functional notes
// - wake-critical bit starts from strap level
// - bit clear: wake allowed in critical region
// - bit set: no wake in critical region
// - supply events counted only when enabled
// - super bit clear blocks wake above threshold
// - powerdown bit switches off network detector
// - reset low while supply bad, then delay
// - network delay codes 1.2 to 10 ms
// - network delay only for network wake cause
// - mask gates interrupt, never the flag
// - mask bit layout, used bits reset one
// - activity flags set on any status change
// - voltage flag set on any supply state change
// - temperature 11-bit, integer and fraction registers
// - upper limit 7 bits, alert rising above
// - alert again below limit minus hysteresis
// - upper falling check armed after rising alert
// - lower limit signed, alert below then above
// - lower rising check armed after falling alert
// - unmasked thermal alert asserts interrupt pin
// - hysteresis five bits, default five degrees
`include "wake_cfg_consts.svh"

module wake_config_mask_temp_alert #(
    parameter logic [15:0] TICK_CYCLES = 16'(`TICK_CYCLES)
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        wake_level_strap_i,
    input  wire logic        sleep_i,
    input  wire logic        over_supply_state_i,
    input  wire logic        critical_supply_state_i,
    input  wire logic        under_supply_state_i,
    input  wire logic        supply_event_i,
    input  wire logic        lin_active_i,
    input  wire logic        switch_active_i,
    input  wire logic        status_active_i,
    input  wire logic        net_active_i,
    input  wire logic [7:0]  flag_clear_i,
    input  wire logic        power_applied_clear_i,
    input  wire logic [10:0] temp_sample_i,
    input  wire logic        temp_valid_i,
    input  wire logic        peripheral_supply_good_i,
    input  wire logic        net_activity_cause_i,
    input  wire logic [6:0]  gen_delay_ticks_i,
    output logic             wake_permit_o,
    output logic             supply_event_disable_o,
    output logic             net_detector_powerdown_o,
    output logic      [7:0]  event_flags_o,
    output logic             power_applied_flag_o,
    output logic             int_n_o,
    output logic             reset_out_n_o
);

    wake_cfg_pkg::bank_state_s st;
    wake_cfg_pkg::bank_state_s next_st;

    // ********
    // network wake delay table, in divider ticks
    // ********
    function automatic logic [6:0] net_delay_ticks(input logic [2:0] code);
        logic [6:0] t;
        case (code)
            3'h0:    t = 7'(`US_TO_TICKS(`NET_DELAY_US_0));
            3'h1:    t = 7'(`US_TO_TICKS(`NET_DELAY_US_1));
            3'h2:    t = 7'(`US_TO_TICKS(`NET_DELAY_US_2));
            3'h3:    t = 7'(`US_TO_TICKS(`NET_DELAY_US_3));
            3'h4:    t = 7'(`US_TO_TICKS(`NET_DELAY_US_4));
            3'h5:    t = 7'(`US_TO_TICKS(`NET_DELAY_US_5));
            3'h6:    t = 7'(`US_TO_TICKS(`NET_DELAY_US_6));
            default: t = 7'(`US_TO_TICKS(`NET_DELAY_US_7));
        endcase
        return t;
    endfunction : net_delay_ticks

    // ********
    // temperature levels in eighths of a degree
    // ********
    logic signed [11:0] temp_now;
    logic signed [11:0] upper_level;
    logic signed [11:0] upper_fall_level;
    logic signed [11:0] lower_level;
    logic signed [8:0]  fall_degrees;

    always_comb begin
        temp_now         = {st.temperature[10], st.temperature};
        upper_level      = {2'b00, st.upper_degree_limit, 3'b000};
        // limit minus band can go below zero, so keep the sign
        fall_degrees     = $signed({2'b00, st.upper_degree_limit})
                         - $signed({4'b0000, st.upper_band_width});
        lower_level      = {st.lower_degree_limit[7], st.lower_degree_limit, 3'b000};
        upper_fall_level = {fall_degrees, 3'b000};
    end

    // ********
    // next state
    // ********
    logic       wr_cfg;
    logic       wr_mask;
    logic       wr_upper;
    logic       wr_lower;
    logic       wr_band;
    logic       sleep_exit;
    logic       thermal_set;
    logic [7:0] set_flags;
    logic [3:0] activity_now;
    logic [2:0] supply_now;

    always_comb begin
        next_st      = st;
        wr_cfg       = reg_wr_i && (reg_addr_i == `ADDR_WAKE_CONFIGURATION);
        wr_mask      = reg_wr_i && (reg_addr_i == `ADDR_INTERRUPT_MASK);
        wr_upper     = reg_wr_i && (reg_addr_i == `ADDR_TEMPERATURE_UPPER_LIMIT);
        wr_lower     = reg_wr_i && (reg_addr_i == `ADDR_TEMPERATURE_LOWER_LIMIT);
        wr_band      = reg_wr_i && (reg_addr_i == `ADDR_UPPER_LIMIT_HYSTERESIS);
        sleep_exit   = st.prev_sleep && !sleep_i;
        thermal_set  = 1'b0;
        set_flags    = 8'h00;
        activity_now = {lin_active_i, switch_active_i, status_active_i, net_active_i};
        supply_now   = {over_supply_state_i, critical_supply_state_i, under_supply_state_i};

        // strap caught on the first edge after reset release
        if (!st.strap_taken) begin
            next_st.strap_taken             = 1'b1;
            next_st.wake_in_critical_region = wake_level_strap_i;
        end

        if (wr_cfg) begin
            next_st.wake_in_critical_region = reg_wdata_i[`CFG_WAKE_CRIT_BIT];
            next_st.supply_event_disable    = reg_wdata_i[`CFG_EVT_DIS_BIT];
            next_st.wake_in_super_region    = reg_wdata_i[`CFG_WAKE_SUPER_BIT];
            next_st.net_detector_powerdown  = reg_wdata_i[`CFG_NET_PD_BIT];
            next_st.net_wake_reset_delay    = reg_wdata_i[`CFG_DELAY_MSB:0];
        end
        if (wr_mask) begin
            next_st.mask = reg_wdata_i & `MASK_USED;
        end
        if (wr_upper) begin
            next_st.upper_degree_limit = reg_wdata_i[6:0];
        end
        if (wr_lower) begin
            next_st.lower_degree_limit = reg_wdata_i;
        end
        if (wr_band) begin
            next_st.upper_band_width = reg_wdata_i[4:0];
        end
        if (temp_valid_i) begin
            next_st.temperature = temp_sample_i;
        end

        // upper limit: rising check first, falling armed by a rising alert
        if (sleep_exit || wr_upper) begin
            next_st.high_check = wake_cfg_pkg::HI_WATCH_RISE;
        end else begin
            case (st.high_check)
                wake_cfg_pkg::HI_WATCH_RISE: begin
                    if (temp_now > upper_level) begin
                        thermal_set        = 1'b1;
                        next_st.high_check = wake_cfg_pkg::HI_WATCH_FALL;
                    end
                end
                wake_cfg_pkg::HI_WATCH_FALL: begin
                    if (temp_now < upper_fall_level) begin
                        thermal_set        = 1'b1;
                        next_st.high_check = wake_cfg_pkg::HI_WATCH_RISE;
                    end
                end
                default: begin
                    next_st.high_check = wake_cfg_pkg::HI_WATCH_RISE;
                end
            endcase
        end

        // lower limit: falling check first, rising armed by a falling alert
        if (sleep_exit || wr_lower) begin
            next_st.low_check = wake_cfg_pkg::LO_WATCH_FALL;
        end else begin
            case (st.low_check)
                wake_cfg_pkg::LO_WATCH_FALL: begin
                    if (temp_now < lower_level) begin
                        thermal_set       = 1'b1;
                        next_st.low_check = wake_cfg_pkg::LO_WATCH_RISE;
                    end
                end
                wake_cfg_pkg::LO_WATCH_RISE: begin
                    if (temp_now > lower_level) begin
                        thermal_set       = 1'b1;
                        next_st.low_check = wake_cfg_pkg::LO_WATCH_FALL;
                    end
                end
                default: begin
                    next_st.low_check = wake_cfg_pkg::LO_WATCH_FALL;
                end
            endcase
        end

        // change detectors stay quiet until the first sample is held
        next_st.prev_activity = activity_now;
        next_st.prev_supply   = supply_now;
        next_st.prev_sleep    = sleep_i;
        if (st.strap_taken) begin
            set_flags[`MASK_LIN_BIT]    = activity_now[3] ^ st.prev_activity[3];
            set_flags[`MASK_SWITCH_BIT] = activity_now[2] ^ st.prev_activity[2];
            set_flags[`MASK_STATUS_BIT] = activity_now[1] ^ st.prev_activity[1];
            set_flags[`MASK_NET_BIT]    = activity_now[0] ^ st.prev_activity[0];
            set_flags[`MASK_SUPPLY_BIT] = |(supply_now ^ st.prev_supply);
        end
        set_flags[`MASK_THERMAL_BIT] = thermal_set;

        // a set arriving with its clear wins; mask never touches the flags
        next_st.flags = ((st.flags & ~flag_clear_i) | set_flags) & `MASK_USED;
        next_st.power_applied_flag = (st.power_applied_flag & ~power_applied_clear_i)
                                   | (supply_event_i & ~st.supply_event_disable);

        next_st.int_n = ~|(next_st.flags & ~next_st.mask);

        // allowed wakeup window
        next_st.wake_permit = !under_supply_state_i
                           && !(st.wake_in_critical_region && critical_supply_state_i)
                           && !(!st.wake_in_super_region && over_supply_state_i);

        next_st.delay_ticks = net_activity_cause_i
                            ? net_delay_ticks(st.net_wake_reset_delay)
                            : gen_delay_ticks_i;

        // register read data
        if (reg_rd_i) begin
            case (reg_addr_i)
                `ADDR_WAKE_CONFIGURATION: begin
                    next_st.rdata = {st.wake_in_critical_region, st.supply_event_disable,
                                     st.wake_in_super_region, st.net_detector_powerdown,
                                     1'b0, st.net_wake_reset_delay};
                end
                `ADDR_INTERRUPT_MASK:          next_st.rdata = st.mask;
                `ADDR_TEMPERATURE_INTEGER:     next_st.rdata = st.temperature[10:3];
                `ADDR_TEMPERATURE_FRACTION: begin
                    next_st.rdata = {st.temperature[2:0], 5'h00};
                end
                `ADDR_TEMPERATURE_UPPER_LIMIT: next_st.rdata = {1'b0, st.upper_degree_limit};
                `ADDR_TEMPERATURE_LOWER_LIMIT: next_st.rdata = st.lower_degree_limit;
                `ADDR_UPPER_LIMIT_HYSTERESIS:  next_st.rdata = {3'h0, st.upper_band_width};
                default:                       next_st.rdata = 8'h00;
            endcase
        end
    end

    // ********
    // state register
    // ********
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.wake_in_critical_region <= 1'b0;
            st.supply_event_disable    <= `CFG_EVT_DIS_RESET;
            st.wake_in_super_region    <= `CFG_WAKE_SUPER_RESET;
            st.net_detector_powerdown  <= `CFG_NET_PD_RESET;
            st.net_wake_reset_delay    <= `CFG_DELAY_RESET;
            st.strap_taken             <= 1'b0;
            st.mask                    <= `MASK_RESET;
            st.temperature             <= `TEMPERATURE_RESET;
            st.upper_degree_limit      <= `UPPER_LIMIT_RESET;
            st.lower_degree_limit      <= `LOWER_LIMIT_RESET;
            st.upper_band_width        <= `BAND_WIDTH_RESET;
            st.high_check              <= wake_cfg_pkg::HI_WATCH_RISE;
            st.low_check               <= wake_cfg_pkg::LO_WATCH_FALL;
            st.prev_activity           <= 4'h0;
            st.prev_supply             <= 3'h0;
            st.prev_sleep              <= 1'b0;
            st.flags                   <= 8'h00;
            st.power_applied_flag      <= 1'b1;
            st.int_n                   <= 1'b1;
            st.wake_permit             <= 1'b0;
            st.rdata                   <= 8'h00;
            st.delay_ticks             <= 7'h00;
        end else begin
            st <= next_st;
        end
    end

    // ********
    // reset output generator
    // ********
    reset_release_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_release (
        .sys_clk_i     (sys_clk_i),
        .rst_n_i       (rst_n_i),
        .supply_good_i (peripheral_supply_good_i),
        .delay_ticks_i (st.delay_ticks),
        .reset_out_n_o (reset_out_n_o)
    );

    assign reg_rdata_o              = st.rdata;
    assign wake_permit_o            = st.wake_permit;
    assign supply_event_disable_o   = st.supply_event_disable;
    assign net_detector_powerdown_o = st.net_detector_powerdown;
    assign event_flags_o            = st.flags;
    assign power_applied_flag_o     = st.power_applied_flag;
    assign int_n_o                  = st.int_n;

endmodule : wake_config_mask_temp_alert

// ---- tb/wake_config_mask_temp_alert_asserts.sv ----
// port checker for the wake configuration bank
// ********
// checker
// ********
module wake_config_mask_temp_alert_asserts (
    input wire logic       sys_clk_i,
    input wire logic       rst_n_i,
    input wire logic       reg_rd_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       over_supply_state_i,
    input wire logic       critical_supply_state_i,
    input wire logic       under_supply_state_i,
    input wire logic       supply_event_i,
    input wire logic       lin_active_i,
    input wire logic [7:0] flag_clear_i,
    input wire logic       peripheral_supply_good_i,
    input wire logic       supply_event_disable_o,
    input wire logic [7:0] event_flags_o,
    input wire logic       power_applied_flag_o,
    input wire logic       int_n_o,
    input wire logic       reset_out_n_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
        else $error("read data moved");
    a_flag_sticky: assert property
        ((($past(event_flags_o) & ~event_flags_o) & ~$past(flag_clear_i)) == 8'h00)
        else $error("flag dropped");
    a_lin_flag: assert property ($past(rst_n_i) && $changed(lin_active_i)
        |=> event_flags_o[6]) else $error("lin flag missing");
    a_volt_flag: assert property ($past(rst_n_i) && $changed({over_supply_state_i,
        critical_supply_state_i, under_supply_state_i}) |=> event_flags_o[0])
        else $error("supply flag missing");
    a_int_quiet: assert property (event_flags_o == 8'h00 |-> int_n_o)
        else $error("interrupt without flag");
    a_evt_refused: assert property (supply_event_disable_o && !power_applied_flag_o
        && !reg_wr_i |=> !power_applied_flag_o) else $error("event not refused");
    a_evt_taken: assert property (!supply_event_disable_o && supply_event_i
        |=> power_applied_flag_o) else $error("event lost");
    a_rst_low: assert property (!peripheral_supply_good_i |=> !reset_out_n_o)
        else $error("reset not low");
    a_rst_wait: assert property ($rose(peripheral_supply_good_i)
        |=> !reset_out_n_o [*4]) else $error("reset released early");
endmodule : wake_config_mask_temp_alert_asserts

bind wake_config_mask_temp_alert wake_config_mask_temp_alert_asserts
    wake_config_mask_temp_alert_asserts_i (.*);

// ---- tb/host_port_model.sv ----
// host controller model on the decoded register port
module host_port_model (
    input  wire logic       sys_clk_i,
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_rd_o,
    input  wire logic [7:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o} = '0;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_o    <= 1'b0;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_o   <= 1'b0;
        @(negedge sys_clk_i);
        d = reg_rdata_i;
    endtask : read_reg
endmodule : host_port_model

// ---- tb/wake_config_mask_temp_alert_tb.sv ----
// self-checking bench for the wake configuration bank
module wake_config_mask_temp_alert_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, wake_level_strap_i, sleep_i;
    logic        over_supply_state_i, critical_supply_state_i, under_supply_state_i;
    logic        supply_event_i, lin_active_i, switch_active_i, status_active_i;
    logic        net_active_i, power_applied_clear_i, temp_valid_i, net_activity_cause_i;
    logic        peripheral_supply_good_i, wake_permit_o, supply_event_disable_o;
    logic        net_detector_powerdown_o, power_applied_flag_o, int_n_o, reset_out_n_o;
    logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, flag_clear_i, event_flags_o, rdv;
    logic [10:0] temp_sample_i;
    logic [6:0]  gen_delay_ticks_i;
    logic [7:0]  rst_tab [8] = '{8'hE7, 8'h5F, 8'h00, 8'h00, 8'h55, 8'h00, 8'h05, 8'h00};
    int          bad_count, checks_done, n;
    // short tick keeps the long reset delays affordable
    wake_config_mask_temp_alert #(.TICK_CYCLES(16'h0004)) wake_config_mask_temp_alert_i (.*);
    host_port_model host_port_model_i (.sys_clk_i, .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i),
        .reg_rdata_i(reg_rdata_o));
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask : tick
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_port_model_i.read_reg(a, rdv);
        chk(rdv, e);
    endtask : rdchk
    task automatic rst(input logic s);
        @(posedge sys_clk_i);
        rst_n_i            <= 1'b0;
        wake_level_strap_i <= s;
        repeat (4) @(posedge sys_clk_i);
        rst_n_i            <= 1'b1;
        tick(2);
    endtask : rst
    task automatic load(input logic [10:0] t, input logic [7:0] e);
        @(posedge sys_clk_i);
        temp_sample_i <= t;
        temp_valid_i  <= 1'b1;
        @(posedge sys_clk_i);
        temp_valid_i  <= 1'b0;
        tick(3);
        chk(event_flags_o, e);
        chk({7'h00, int_n_o}, {7'h00, ~e[1]});
        @(posedge sys_clk_i);
        flag_clear_i  <= 8'hFF;
        @(posedge sys_clk_i);
        flag_clear_i  <= 8'h00;
    endtask : load
    task automatic evt(input logic [7:0] e);
        @(posedge sys_clk_i);
        power_applied_clear_i <= 1'b1;
        @(posedge sys_clk_i);
        power_applied_clear_i <= 1'b0;
        supply_event_i        <= 1'b1;
        @(posedge sys_clk_i);
        supply_event_i        <= 1'b0;
        tick(1);
        chk({7'h00, power_applied_flag_o}, e);
    endtask : evt
    task automatic rel(input int lo, input int hi);
        @(posedge sys_clk_i);
        peripheral_supply_good_i <= 1'b0;
        tick(2);
        chk({7'h00, reset_out_n_o}, 8'h00);
        @(posedge sys_clk_i);
        peripheral_supply_good_i <= 1'b1;
        n = 0;
        while (reset_out_n_o !== 1'b1 && n < hi) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk({7'h00, n >= lo && n < hi}, 8'h01);
        if (n >= hi)
            test_done();
    endtask : rel
    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {rst_n_i, wake_level_strap_i, sleep_i, over_supply_state_i, supply_event_i} = '0;
        {critical_supply_state_i, under_supply_state_i, lin_active_i, switch_active_i} = '0;
        {status_active_i, net_active_i, power_applied_clear_i, temp_valid_i} = '0;
        {net_activity_cause_i, flag_clear_i, temp_sample_i} = '0;
        peripheral_supply_good_i = 1'b1;
        gen_delay_ticks_i = 7'h02;
        rst(1'b1);
        for (int i = 0; i < 8; i++)
            rdchk(8'(8'h08 + i), rst_tab[i]);
        rst(1'b0);
        rdchk(8'h08, 8'h67);
        $display("test reset values done");
        chk({5'h00, supply_event_disable_o, net_detector_powerdown_o, wake_permit_o}, 8'h05);
        evt(8'h00);
        host_port_model_i.write_reg(8'h08, 8'h17);
        tick(1);
        chk({5'h00, supply_event_disable_o, net_detector_powerdown_o, wake_permit_o}, 8'h03);
        evt(8'h01);
        host_port_model_i.write_reg(8'h09, 8'hFF);
        rdchk(8'h09, 8'h5F);
        host_port_model_i.write_reg(8'h09, 8'h5D);
        $display("test config done");
        load(11'h2B0, 8'h02);
        rdchk(8'h0A, 8'h56);
        host_port_model_i.write_reg(8'h0C, 8'h55);
        load(11'h2B8, 8'h02);
        load(11'h2C0, 8'h00);
        load(11'h280, 8'h00);
        load(11'h27F, 8'h02);
        rdchk(8'h0B, 8'hE0);
        load(11'h7F8, 8'h02);
        load(11'h000, 8'h00);
        load(11'h001, 8'h02);
        $display("test thermal done");
        @(posedge sys_clk_i);
        lin_active_i <= 1'b1;
        tick(2);
        chk(event_flags_o, 8'h40);
        chk({7'h00, int_n_o}, 8'h01);
        host_port_model_i.write_reg(8'h09, 8'h1D);
        tick(1);
        chk({7'h00, int_n_o}, 8'h00);
        @(posedge sys_clk_i);
        under_supply_state_i <= 1'b1;
        tick(2);
        chk(event_flags_o, 8'h41);
        chk({7'h00, wake_permit_o}, 8'h00);
        $display("test events done");
        rel(8, 40);
        @(posedge sys_clk_i);
        net_activity_cause_i <= 1'b1;
        rel(400, 600);
        $display("test reset output done");
        test_done();
    end
endmodule : wake_config_mask_temp_alert_tb
